/* common/dee_pkg.sv */
// shared constants and carrier types for the data storage controller
package dee_pkg;
  // register offsets in the special function space
  localparam logic [7:0] DEE_OFS_DATA = 8'h08;
  localparam logic [7:0] DEE_OFS_ADDR = 8'h09;
  localparam logic [7:0] DEE_OFS_INTCTL = 8'h0b;
  localparam logic [7:0] DEE_OFS_CTRL = 8'h88;
  localparam logic [7:0] DEE_OFS_UNLOCK = 8'h89;
  // control register fields
  localparam int DEE_CTRL_RD_BIT = 0;
  localparam int DEE_CTRL_WR_BIT = 1;
  localparam int DEE_CTRL_WEN_BIT = 2;
  localparam int DEE_CTRL_ABORT_BIT = 3;
  localparam int DEE_CTRL_DONE_BIT = 4;
  localparam int DEE_CTRL_WIDTH = 5;
  // interrupt control fields
  localparam int DEE_INT_GIE_BIT = 7;
  localparam int DEE_INT_DONE_EN_BIT = 6;
  // reset values and erased cell value
  localparam logic [7:0] DEE_INTCTL_RST = 8'h00;
  localparam logic [7:0] DEE_DATA_RST = 8'h00;
  localparam logic [7:0] DEE_ADDR_RST = 8'h00;
  localparam logic [7:0] DEE_ERASED = 8'hff;
  // unlock values
  localparam logic [7:0] DEE_KEY_FIRST = 8'h55;
  localparam logic [7:0] DEE_KEY_SECOND = 8'haa;
  // geometry
  localparam int DEE_DEPTH = 64;
  localparam int DEE_AW = 6;
  localparam int DEE_DW = 8;
  // timing
  localparam int DEE_CLK_HZ = 125_000_000;
  localparam int DEE_WRITE_TIME_MS = 10;
  localparam int DEE_PWRUP_TIME_MS = 72;
  localparam int DEE_WRITE_CYCLES = DEE_CLK_HZ / 1000 * DEE_WRITE_TIME_MS;
  localparam int DEE_PWRUP_CYCLES = DEE_CLK_HZ / 1000 * DEE_PWRUP_TIME_MS;
  localparam int DEE_CNT_W = 24;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dee_sfr_req_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [DEE_AW-1:0] addr;
    logic [DEE_DW-1:0] wdata;
  } dee_prog_req_s;
endpackage

/* verif/dee_core_model.sv */
// core-side register access model for the special function port
`timescale 1ns/10ps
module dee_core_model (
  // clock
  input wire logic core_clk,
  // register port
  output dee_pkg::dee_sfr_req_s sfr_req
);
  initial sfr_req = '0;
  // one access held over one rising edge; idle bus carries junk, not the old value
  task automatic acc(input logic is_wr, input logic [7:0] ad, input logic [7:0] dt,
                     input int gap);
    @(negedge core_clk);
    sfr_req <= {~is_wr, is_wr, ad, dt};
    @(negedge core_clk);
    sfr_req <= {2'b00, 16'($urandom)};
    repeat (gap) @(negedge core_clk);
  endtask
endmodule // dee_core_model

/* verif/dee_ctrl_chk.sv */
// concurrent checks on the storage controller ports
`timescale 1ns/10ps
module dee_ctrl_chk #(
  parameter int WRITE_CYCLES = 8,
  parameter int PWRUP_CYCLES = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic master_clear_pin_reset,
  input wire logic watchdog_timeout,
  // register port
  input wire dee_pkg::dee_sfr_req_s sfr_req,
  input wire logic [7:0] sfr_rdata,
  // programmer port
  input wire logic code_protect,
  input wire dee_pkg::dee_prog_req_s prog_req,
  input wire logic [7:0] prog_rdata,
  input wire logic prog_denied,
  // status
  input wire logic irq,
  input wire logic write_busy
);
  logic warm_q;
  logic [7:0] up_q;
  logic start_req;
  assign start_req = (sfr_req.wr && sfr_req.addr == dee_pkg::DEE_OFS_CTRL && sfr_req.wdata[1])
    || (prog_req.req && prog_req.we && !code_protect);
  // a warm reset excuses a write that ends early
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      warm_q <= 1'b0;
    end else begin
      warm_q <= master_clear_pin_reset || watchdog_timeout || (warm_q && write_busy);
    end
  end
  // saturating age since reset, enough to cover the power-up hold-off
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      up_q <= 8'h00;
    end else if (up_q != 8'hff) begin
      up_q <= up_q + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_busy_hold;
    write_busy [*8];
  endsequence
  sequence s_prog_deny;
    prog_req.req && code_protect;
  endsequence
  property p_busy_len;
    disable iff (!resetn || warm_q || master_clear_pin_reset || watchdog_timeout)
    $rose(write_busy) |-> s_busy_hold ##[1:6] !write_busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_busy_cause;
    $rose(write_busy) |-> $past(start_req) || $past(start_req, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("write began unasked");
  property p_pwrup;
    up_q < 8'(PWRUP_CYCLES + 2) |-> !write_busy;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("write during power-up delay");
  property p_unlock_zero;
    sfr_req.rd && sfr_req.addr == dee_pkg::DEE_OFS_UNLOCK |=> sfr_rdata == 8'h00;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read nonzero");
  property p_ctrl_upper;
    sfr_req.rd && sfr_req.addr == dee_pkg::DEE_OFS_CTRL |=> sfr_rdata[7:5] == 3'h0;
  endproperty
  a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits set");
  property p_rdata_hold;
    !sfr_req.rd |=> $stable(sfr_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_prog_deny;
    s_prog_deny |=> prog_denied && prog_rdata == 8'h00;
  endproperty
  a_prog_deny: assert property (p_prog_deny) else $error("programmer not blocked");
  property p_prog_allow;
    prog_req.req && !code_protect && !prog_req.we |=> !prog_denied;
  endproperty
  a_prog_allow: assert property (p_prog_allow) else $error("programmer wrongly refused");
endmodule // dee_ctrl_chk

bind dee_ctrl dee_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES), .PWRUP_CYCLES(PWRUP_CYCLES))
  u_dee_ctrl_chk (.core_clk(core_clk), .resetn(resetn),
  .master_clear_pin_reset(master_clear_pin_reset), .watchdog_timeout(watchdog_timeout),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .code_protect(code_protect),
  .prog_req(prog_req), .prog_rdata(prog_rdata), .prog_denied(prog_denied),
  .irq(irq), .write_busy(write_busy));

/* verif/dee_ctrl_tb.sv */
// self-checking bench for the data storage controller
`timescale 1ns/10ps
module dee_ctrl_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] warm = 2'b00;
  logic code_protect = 1'b0;
  dee_pkg::dee_prog_req_s prog_req = '0;
  dee_pkg::dee_sfr_req_s sfr_req;
  logic [7:0] sfr_rdata;
  logic [7:0] prog_rdata;
  logic prog_denied;
  logic irq;
  logic write_busy;
  logic rd_seen = 1'b0;
  logic [7:0] expq[$];
  logic [7:0] a;
  logic [7:0] d;
  logic [7:0] gd;
  int n_mismatch = 0;
  int checks = 0;
  always #4 core_clk = ~core_clk;
  dee_core_model u_dee_core_model (.core_clk(core_clk), .sfr_req(sfr_req));
  dee_ctrl #(.WRITE_CYCLES(8), .PWRUP_CYCLES(4)) u_dee_ctrl (.core_clk(core_clk),
    .resetn(resetn), .master_clear_pin_reset(warm[0]), .watchdog_timeout(warm[1]),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .code_protect(code_protect),
    .prog_req(prog_req), .prog_rdata(prog_rdata), .prog_denied(prog_denied),
    .irq(irq), .write_busy(write_busy));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    u_dee_core_model.acc(1'b1, ad, dt, $urandom_range(2));
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
    expq.push_back(ex);
    u_dee_core_model.acc(1'b0, ad, 8'($urandom), $urandom_range(2));
  endtask
  // unlock then start; the start write is sent with no gap so busy can be seen at once
  task automatic start(input logic en);
    wr(8'h88, {5'h00, en, 2'b00});
    wr(8'h89, 8'h55);
    wr(8'h89, 8'haa);
    u_dee_core_model.acc(1'b1, 8'h88, 8'h06, 0);
    @(negedge core_clk);
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 100 && write_busy !== 1'b0; i++) @(negedge core_clk);
    if (i == 100) begin
      n_mismatch++;
      test_done();
    end
  endtask
  // results land one cycle after the read strobe
  always @(posedge core_clk) rd_seen <= sfr_req.rd;
  always @(negedge core_clk) begin
    if (rd_seen === 1'b1 && expq.size() > 0) begin
      chk("sfr_rdata", sfr_rdata, expq.pop_front());
    end
  end
  initial begin
    void'($urandom(93953));
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    repeat (2) @(negedge core_clk);
    prog_req = {1'b1, 1'b1, 6'h00, 8'($urandom)};
    @(negedge core_clk);
    prog_req = '0;
    chk("prog_denied", {7'h00, prog_denied}, 8'h01);
    chk("write_busy", {7'h00, write_busy}, 8'h00);
    repeat (20) @(negedge core_clk);
    rd(8'h89, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'h20, 8'h00);
    start(1'b0);
    chk("write_busy", {7'h00, write_busy}, 8'h00);
    wr(8'h88, 8'h04);
    wr(8'h89, 8'h55);
    rd(8'h08, 8'h00);
    wr(8'h89, 8'haa);
    wr(8'h88, 8'h06);
    @(negedge core_clk);
    chk("write_busy", {7'h00, write_busy}, 8'h00);
    wr(8'h09, 8'h40);
    start(1'b1);
    chk("write_busy", {7'h00, write_busy}, 8'h00);
    wr(8'h88, 8'h01);
    rd(8'h08, 8'h00);
    wr(8'h0b, 8'hc0);
    for (int k = 0; k < 2; k++) begin
      a = (k == 1) ? 8'h3f : {2'b00, 6'($urandom)};
      d = 8'($urandom);
      wr(8'h09, a);
      wr(8'h08, d);
      wr(8'h0b, 8'h40);
      start(1'b1);
      chk("write_busy", {7'h00, write_busy}, 8'h01);
      wr(8'h88, (k == 1) ? 8'h00 : 8'h04);
      rd(8'h88, (k == 1) ? 8'h02 : 8'h06);
      wait_idle();
      @(negedge core_clk);
      chk("irq", {7'h00, irq}, 8'h00);
      wr(8'h0b, 8'hc0);
      repeat (2) @(negedge core_clk);
      chk("irq", {7'h00, irq}, 8'h01);
      rd(8'h88, (k == 1) ? 8'h10 : 8'h14);
      wr(8'h08, ~d);
      wr(8'h88, 8'h01);
      rd(8'h08, d);
    end
    gd = d;
    for (int k = 0; k < 2; k++) begin
      a = {2'b00, 6'($urandom)};
      d = 8'($urandom);
      wr(8'h09, a);
      wr(8'h08, d);
      start(1'b1);
      warm[k] = 1'b1;
      repeat (2) @(negedge core_clk);
      warm[k] = 1'b0;
      wait_idle();
      rd(8'h88, 8'h08);
      rd(8'h09, a);
      rd(8'h08, d);
    end
    code_protect = 1'b1;
    prog_req = {1'b1, 1'b0, 6'h3f, 8'($urandom)};
    @(negedge core_clk);
    prog_req = '0;
    chk("prog_denied", {7'h00, prog_denied}, 8'h01);
    wr(8'h09, 8'h3f);
    wr(8'h88, 8'h01);
    rd(8'h08, gd);
    code_protect = 1'b0;
    prog_req = {1'b1, 1'b0, 6'h3f, 8'($urandom)};
    @(negedge core_clk);
    prog_req = '0;
    chk("prog_rdata", prog_rdata, gd);
    repeat (4) @(negedge core_clk);
    chk("pending", 8'(expq.size()), 8'h00);
    test_done();
  end
endmodule // dee_ctrl_tb

/* verilog/dee_cell_array.sv */
// byte storage with timed erase-then-program write cycle
`timescale 1ns/10ps
module dee_cell_array #(
  parameter int DEPTH = dee_pkg::DEE_DEPTH,
  parameter int AW = dee_pkg::DEE_AW,
  parameter int DW = dee_pkg::DEE_DW,
  parameter int WRITE_CYCLES = dee_pkg::DEE_WRITE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write cycle control
  input wire logic start,
  input wire logic abort,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  output logic busy,
  output logic done,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  typedef enum logic [1:0] {DEE_A_IDLE, DEE_A_ERASE, DEE_A_PROG} dee_aphase_e;
  localparam int HALF = (WRITE_CYCLES / 2 > 0) ? WRITE_CYCLES / 2 : 1;

  dee_aphase_e phase_q;
  logic [dee_pkg::DEE_CNT_W-1:0] cnt_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic [DW-1:0] mem_q [DEPTH];
  logic tick;

  assign tick = (cnt_q == dee_pkg::DEE_CNT_W'(HALF - 1));
  assign busy = (phase_q != DEE_A_IDLE);
  assign rd_data = mem_q[rd_addr];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= DEE_A_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        phase_q <= DEE_A_IDLE;
        cnt_q <= '0;
      end else begin
        unique case (phase_q)
          DEE_A_IDLE: begin
            if (start) begin
              phase_q <= DEE_A_ERASE;
              addr_q <= wr_addr;
              data_q <= wr_data;
              cnt_q <= '0;
            end
          end
          DEE_A_ERASE: begin
            cnt_q <= tick ? '0 : cnt_q + 1'b1;
            if (tick) phase_q <= DEE_A_PROG;
          end
          DEE_A_PROG: begin
            cnt_q <= tick ? '0 : cnt_q + 1'b1;
            if (tick) begin
              phase_q <= DEE_A_IDLE;
              done <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // contents are non-volatile: no reset on the cells
  always_ff @(posedge clk) begin
    if (phase_q == DEE_A_ERASE && tick) begin
      mem_q[addr_q] <= dee_pkg::DEE_ERASED;
    end else if (phase_q == DEE_A_PROG && tick && !abort) begin
      mem_q[addr_q] <= data_q;
    end
  end
endmodule // dee_cell_array

/* verilog/dee_ctrl.sv */
// data storage controller reached through special function registers
`timescale 1ns/10ps
// Summary of operation
// - 64 bytes, each readable and writable, at locations 00h to 3Fh.
// - address register is 8 bits; upper two bits must be zero to hit storage.
// - each byte write erases the location first, then programs it.
// - internal timer sets the write time, about 10 ms; completion is flagged.
// - with code protection the core still reads and writes; programmer is blocked.
// - control register has five bits; upper three read zero.
// - read and write start bits are set by software, cleared only by hardware.
// - write enable latch cleared at power-up, never cleared by a finished write.
// - pin or watchdog reset during a core write sets abort flag; data and address kept.
// - end of write clears write start and sets done flag; software clears done.
// - unlock register has no storage and reads zero.
// - read loads the data register next cycle; held until another read or write.
// - write needs 55h then AAh to unlock register, then write start.
// - write start refused unless write enable latch is set.
// - clearing write enable during a write does not disturb it.
// - no write may start during the 72 ms power-up delay.
module dee_ctrl #(
  parameter int WRITE_CYCLES = dee_pkg::DEE_WRITE_CYCLES,
  parameter int PWRUP_CYCLES = dee_pkg::DEE_PWRUP_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // warm resets, held high for the reset
  input wire logic master_clear_pin_reset,
  input wire logic watchdog_timeout,
  // special function register port
  input wire dee_pkg::dee_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  // external programming port
  input wire logic code_protect,
  input wire dee_pkg::dee_prog_req_s prog_req,
  output logic [7:0] prog_rdata,
  output logic prog_denied,
  // status
  output logic irq,
  output logic write_busy
);
  typedef enum logic [1:0] {DEE_UL_IDLE, DEE_UL_GOT_FIRST, DEE_UL_ARMED} dee_unlock_e;

  logic rst_meta_q;
  logic rst_n;
  logic [7:0] data_q;
  logic [7:0] addr_q;
  logic [7:0] intctl_q;
  logic rd_q;
  logic wr_q;
  logic wen_q;
  logic abort_q;
  logic done_q;
  dee_unlock_e unlock_q;
  logic [dee_pkg::DEE_CNT_W-1:0] pwrup_cnt_q;
  logic pwrup_done_q;
  logic core_owner_q;
  logic warm_rst;
  logic wr_ctrl;
  logic wr_unlock;
  logic core_start;
  logic prog_start;
  logic arr_start;
  logic arr_busy;
  logic arr_done;
  logic arr_abort;
  logic [dee_pkg::DEE_AW-1:0] arr_wr_addr;
  logic [7:0] arr_wr_data;
  logic [dee_pkg::DEE_AW-1:0] arr_rd_addr;
  logic [7:0] arr_rd_data;
  logic prog_ok;
  logic [7:0] ctrl_view;
  logic [7:0] rdata_d;
  logic key_ok;
  logic latch_ok;
  logic delay_ok;
  logic space_ok;
  logic core_done;

  // location inside the implemented space only when the two top bits are zero
  function automatic logic in_space(input logic [7:0] a);
    return a[7:6] == 2'b00;
  endfunction

  function automatic logic hit(input dee_pkg::dee_sfr_req_s r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  assign warm_rst = master_clear_pin_reset | watchdog_timeout;
  assign wr_ctrl = hit(sfr_req, dee_pkg::DEE_OFS_CTRL);
  assign wr_unlock = hit(sfr_req, dee_pkg::DEE_OFS_UNLOCK);

  // guards kept apart so a refused start can be traced to its cause
  assign key_ok = (unlock_q == DEE_UL_ARMED);
  assign latch_ok = wen_q;
  assign delay_ok = pwrup_done_q;
  assign space_ok = in_space(addr_q);

  // the start condition needs key, latch, expired delay and an idle array
  assign core_start = !warm_rst && wr_ctrl && sfr_req.wdata[dee_pkg::DEE_CTRL_WR_BIT]
    && !wr_q && key_ok && latch_ok && delay_ok && space_ok && !arr_busy;

  // programmer yields to the core and is shut out by protection
  assign prog_ok = prog_req.req && !code_protect;
  assign prog_start = prog_ok && prog_req.we && !core_start && !arr_busy && pwrup_done_q;
  assign arr_start = core_start | prog_start;
  assign arr_wr_addr = core_start ? addr_q[dee_pkg::DEE_AW-1:0] : prog_req.addr;
  assign arr_wr_data = core_start ? data_q : prog_req.wdata;
  assign arr_rd_addr = rd_q ? addr_q[dee_pkg::DEE_AW-1:0] : prog_req.addr;
  // a warm reset only aborts a cycle the core owns; a programmer cycle runs on
  assign arr_abort = warm_rst && core_owner_q;
  // completion only counts for a write the core launched
  assign core_done = arr_done && core_owner_q;

  dee_cell_array #(
    .DEPTH(dee_pkg::DEE_DEPTH),
    .AW(dee_pkg::DEE_AW),
    .DW(dee_pkg::DEE_DW),
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_cells (
    .clk(core_clk),
    .rst_n(rst_n),
    .start(arr_start),
    .abort(arr_abort),
    .wr_addr(arr_wr_addr),
    .wr_data(arr_wr_data),
    .busy(arr_busy),
    .done(arr_done),
    .rd_addr(arr_rd_addr),
    .rd_data(arr_rd_data)
  );

  // power-up delay, counted once from reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrup_cnt_q <= '0;
      pwrup_done_q <= 1'b0;
    end else if (!pwrup_done_q) begin
      pwrup_cnt_q <= pwrup_cnt_q + 1'b1;
      if (pwrup_cnt_q == dee_pkg::DEE_CNT_W'(PWRUP_CYCLES - 1)) begin
        pwrup_done_q <= 1'b1;
      end
    end
  end

  // unlock detector
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_q <= DEE_UL_IDLE;
    end else if (warm_rst) begin
      unlock_q <= DEE_UL_IDLE;
    end else if (wr_unlock) begin
      if (sfr_req.wdata == dee_pkg::DEE_KEY_FIRST) begin
        unlock_q <= DEE_UL_GOT_FIRST;
      end else if (unlock_q == DEE_UL_GOT_FIRST
          && sfr_req.wdata == dee_pkg::DEE_KEY_SECOND) begin
        unlock_q <= DEE_UL_ARMED;
      end else begin
        unlock_q <= DEE_UL_IDLE;
      end
    end else if (sfr_req.wr || sfr_req.rd) begin
      unlock_q <= DEE_UL_IDLE;
    end
  end

  // data register: survives warm reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= dee_pkg::DEE_DATA_RST;
    end else if (rd_q) begin
      data_q <= in_space(addr_q) ? arr_rd_data : 8'h00;
    end else if (hit(sfr_req, dee_pkg::DEE_OFS_DATA)) begin
      data_q <= sfr_req.wdata;
    end
  end

  // address register: survives warm reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= dee_pkg::DEE_ADDR_RST;
    end else if (hit(sfr_req, dee_pkg::DEE_OFS_ADDR)) begin
      addr_q <= sfr_req.wdata;
    end
  end

  // interrupt control, cleared by any reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      intctl_q <= dee_pkg::DEE_INTCTL_RST;
    end else if (warm_rst) begin
      intctl_q <= dee_pkg::DEE_INTCTL_RST;
    end else if (hit(sfr_req, dee_pkg::DEE_OFS_INTCTL)) begin
      intctl_q <= sfr_req.wdata;
    end
  end

  // read start: set by software, dropped after one load cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
    end else if (warm_rst) begin
      rd_q <= 1'b0;
    end else if (rd_q) begin
      rd_q <= 1'b0;
    end else if (wr_ctrl && sfr_req.wdata[dee_pkg::DEE_CTRL_RD_BIT]) begin
      rd_q <= 1'b1;
    end
  end

  // write start: only hardware clears it, at completion or reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
    end else if (warm_rst) begin
      wr_q <= 1'b0;
    end else if (core_start) begin
      wr_q <= 1'b1;
    end else if (core_done) begin
      wr_q <= 1'b0;
    end
  end

  // remembers who launched the running cycle, so done and abort reach the right side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_owner_q <= 1'b0;
    end else if (arr_start) begin
      core_owner_q <= core_start;
    end else if (!arr_busy || arr_abort) begin
      core_owner_q <= 1'b0;
    end
  end

  // write enable latch: set by software only, cleared by software or warm reset; the write cycle ignores later changes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wen_q <= 1'b0;
    end else if (warm_rst) begin
      wen_q <= 1'b0;
    end else if (wr_ctrl) begin
      wen_q <= sfr_req.wdata[dee_pkg::DEE_CTRL_WEN_BIT];
    end
  end

  // abort flag: a warm reset hitting a core write sets it; set beats software clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_q <= 1'b0;
    end else if (arr_abort) begin
      abort_q <= 1'b1;
    end else if (wr_ctrl) begin
      abort_q <= sfr_req.wdata[dee_pkg::DEE_CTRL_ABORT_BIT];
    end
  end

  // done flag: completion wins over a software clear in the same cycle; a warm reset wins over completion
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (core_done && !warm_rst) begin
      done_q <= 1'b1;
    end else if (warm_rst) begin
      done_q <= 1'b0;
    end else if (wr_ctrl) begin
      done_q <= sfr_req.wdata[dee_pkg::DEE_CTRL_DONE_BIT];
    end
  end

  // control view built by field position; unimplemented bits stay zero
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[dee_pkg::DEE_CTRL_RD_BIT] = rd_q;
    ctrl_view[dee_pkg::DEE_CTRL_WR_BIT] = wr_q;
    ctrl_view[dee_pkg::DEE_CTRL_WEN_BIT] = wen_q;
    ctrl_view[dee_pkg::DEE_CTRL_ABORT_BIT] = abort_q;
    ctrl_view[dee_pkg::DEE_CTRL_DONE_BIT] = done_q;
  end

  // read mux for the register port
  // unmapped offsets and the storage-less unlock port read as zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (sfr_req.addr)
      dee_pkg::DEE_OFS_DATA: rdata_d = data_q;
      dee_pkg::DEE_OFS_ADDR: rdata_d = addr_q;
      dee_pkg::DEE_OFS_INTCTL: rdata_d = intctl_q;
      dee_pkg::DEE_OFS_CTRL: rdata_d = ctrl_view;
      dee_pkg::DEE_OFS_UNLOCK: rdata_d = 8'h00;
      default: rdata_d = 8'h00;
    endcase
  end

  // read data registered and held until the next read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd) begin
      sfr_rdata <= rdata_d;
    end
  end

  // programmer port: answered next cycle, zero while refused
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_rdata <= 8'h00;
      prog_denied <= 1'b0;
    end else begin
      prog_denied <= prog_req.req && (code_protect || (prog_req.we && !prog_start));
      if (prog_ok && !prog_req.we && !rd_q) begin
        prog_rdata <= arr_rd_data;
      end else if (prog_req.req) begin
        prog_rdata <= 8'h00;
      end
    end
  end

  // level interrupt from the latched flag and both enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
      write_busy <= 1'b0;
    end else begin
      irq <= done_q && intctl_q[dee_pkg::DEE_INT_DONE_EN_BIT]
        && intctl_q[dee_pkg::DEE_INT_GIE_BIT];
      write_busy <= arr_busy || arr_start;
    end
  end
endmodule // dee_ctrl
